// file: design/dcsf_regs.sv
`include "dcsf_map.svh"
`default_nettype none
module dcsf_regs import dcsf_pkg::*; #(
	parameter dcsf_result_t SHORT_LIMIT = `DCSF_SHORT_LIMIT
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic [1:0] passSwitchOn,
	input wire logic generalPinOne,
	input wire logic generalPinTwo,
	input wire logic [1:0] activateN,
	input wire logic [1:0] powerGoodFeedback,
	input wire logic [1:0] inputLowLimitPin,
	input wire logic [1:0] inputHighLimitPin,
	input wire logic [1:0] overcurrentPin,
	input wire logic [5:0] alertEnableOne,
	input wire logic [5:0] alertEnableTwo,
	input wire logic convHalt,
	input wire logic convSingleReq,
	input wire logic [2:0] convSingleSel,
	input wire logic convResValid,
	input wire logic [2:0] convResChan,
	input wire logic [9:0] convResData,
	output logic convFreeRun,
	output logic convSingleGo,
	output logic [2:0] convSingleChan,
	output logic hostAlert
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dcsf_pins_t prevPins;
		logic [1:0] armCnt;
		logic [1:0] shortDet;
		dcsf_log_t logOne;
		dcsf_log_t logTwo;
		dcsf_byte_t rdData;
		logic rdFromMem;
		logic rdLow;
		logic alert;
		logic freeRun;
		logic singleGo;
		dcsf_code_t singleChan;
		logic [2:0] rdIdx;
	} dcsf_state_t;
	dcsf_state_t st_r;
	dcsf_state_t st_nxt;

	dcsf_pins_t rawPins;
	dcsf_pins_t pins;
	logic armed;
	logic [1:0] shuntHit;
	logic [1:0] shuntSeen;
	dcsf_log_t evOne;
	dcsf_log_t evTwo;
	dcsf_byte_t liveOne;
	dcsf_byte_t liveTwo;
	logic inResult;
	logic [7:0] resOffset;
	logic [2:0] resIdx;
	logic memWe;
	logic [2:0] memWrAddr;
	dcsf_result_t memWrData;
	dcsf_result_t memWrMask;
	dcsf_result_t memQ;
	logic [2:0] memRdAddr;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_comb begin
		rawPins.genPin = {generalPinTwo, generalPinOne};
		rawPins.actN = activateN;
		rawPins.pGood = powerGoodFeedback;
		rawPins.lowLim = inputLowLimitPin;
		rawPins.highLim = inputHighLimitPin;
		rawPins.overCur = overcurrentPin;
	end

	dcsf_sync #(
		.WIDTH($bits(dcsf_pins_t))
	) u_pinSync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.asyncIn(rawPins),
		.syncOut(pins)
	);

	// ----------------------------------------
	// Live state and events
	// ----------------------------------------
	function automatic dcsf_byte_t liveByte(input dcsf_pins_t p, input logic sw, input logic sh, input int c);
		dcsf_byte_t b;
		b = `DCSF_RESET_BYTE;
		b[`DCSF_BIT_SWITCH_ON] = sw;
		b[`DCSF_BIT_GEN_PIN] = p.genPin[c];
		b[`DCSF_BIT_SHORT] = sh;
		b[`DCSF_BIT_ACTIVE] = ~p.actN[c];
		b[`DCSF_BIT_POWER_BAD] = ~p.pGood[c];
		b[`DCSF_BIT_OVERCURRENT] = p.overCur[c];
		b[`DCSF_BIT_UNDERVOLT] = ~p.lowLim[c];
		b[`DCSF_BIT_OVERVOLT] = p.highLim[c];
		return b;
	endfunction

	// Edges are ignored until the synchronisers hold real pin levels
	function automatic dcsf_log_t edgeEvents(input dcsf_pins_t p, input dcsf_pins_t q, input logic hit, input int c,
			input logic arm);
		dcsf_log_t e;
		e = `DCSF_RESET_LOG;
		e[`DCSF_BIT_SHORT] = hit;
		e[`DCSF_BIT_ACTIVE] = arm & (p.actN[c] ^ q.actN[c]);
		e[`DCSF_BIT_POWER_BAD] = arm & q.pGood[c] & ~p.pGood[c];
		e[`DCSF_BIT_OVERCURRENT] = arm & p.overCur[c] & ~q.overCur[c];
		e[`DCSF_BIT_UNDERVOLT] = arm & q.lowLim[c] & ~p.lowLim[c];
		e[`DCSF_BIT_OVERVOLT] = arm & p.highLim[c] & ~q.highLim[c];
		return e;
	endfunction

	assign armed = (st_r.armCnt == `DCSF_ARM_CYCLES);
	assign shuntSeen[0] = convResValid && (convResChan == `DCSF_SHUNT_CODE_ONE);
	assign shuntSeen[1] = convResValid && (convResChan == `DCSF_SHUNT_CODE_TWO);
	// Short check uses the switch state at the moment the reading lands
	assign shuntHit[0] = shuntSeen[0] && (convResData > SHORT_LIMIT) && !passSwitchOn[0];
	assign shuntHit[1] = shuntSeen[1] && (convResData > SHORT_LIMIT) && !passSwitchOn[1];
	assign liveOne = liveByte(pins, passSwitchOn[0], st_r.shortDet[0], 0);
	assign liveTwo = liveByte(pins, passSwitchOn[1], st_r.shortDet[1], 1);
	assign evOne = edgeEvents(pins, st_r.prevPins, shuntHit[0], 0, armed);
	assign evTwo = edgeEvents(pins, st_r.prevPins, shuntHit[1], 1, armed);

	// ----------------------------------------
	// Converter result storage
	// ----------------------------------------
	assign resOffset = regAddr - `DCSF_OFF_RES_FIRST;
	assign inResult = (regAddr >= `DCSF_OFF_RES_FIRST) && (regAddr <= `DCSF_OFF_RES_LAST);
	assign resIdx = resOffset[3:1];
	// Held index keeps a result read standing after the address moves on
	assign memRdAddr = regRd ? resIdx : st_r.rdIdx;

	// Converter wins a collision; host writes only land while halted
	always_comb begin
		memWe = 1'b0;
		memWrAddr = convResChan;
		memWrData = convResData;
		memWrMask = `DCSF_RES_ALL_MASK;
		if (convResValid) begin
			memWe = 1'b1;
		end else if (regWr && inResult && convHalt) begin
			memWe = 1'b1;
			memWrAddr = resIdx;
			if (regAddr[0]) begin
				memWrData = {8'h00, regWrData[7:6]};
				memWrMask = `DCSF_RES_LO_MASK;
			end else begin
				memWrData = {regWrData, 2'h0};
				memWrMask = `DCSF_RES_HI_MASK;
			end
		end
	end

	dcsf_result_mem #(
		.DEPTH(`DCSF_RES_CHANNELS),
		.WIDTH($bits(dcsf_result_t))
	) u_resMem (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.wrEn(memWe),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.wrMask(memWrMask),
		.rdAddr(memRdAddr),
		.rdData(memQ)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.prevPins = pins;
		if (!armed) begin
			st_nxt.armCnt = st_r.armCnt + 2'h1;
		end
		for (int c = 0; c < 2; c++) begin
			if (shuntSeen[c]) begin
				st_nxt.shortDet[c] = shuntHit[c];
			end
		end
		// Writing one keeps a bit, zero clears it; a new event still wins
		if (regWr && regAddr == `DCSF_OFF_LOG_ONE) begin
			st_nxt.logOne = (st_r.logOne & regWrData[5:0]) | evOne;
		end else begin
			st_nxt.logOne = st_r.logOne | evOne;
		end
		if (regWr && regAddr == `DCSF_OFF_LOG_TWO) begin
			st_nxt.logTwo = (st_r.logTwo & regWrData[5:0]) | evTwo;
		end else begin
			st_nxt.logTwo = st_r.logTwo | evTwo;
		end
		if (regRd) begin
			st_nxt.rdFromMem = inResult;
			st_nxt.rdLow = regAddr[0];
			st_nxt.rdIdx = resIdx;
			unique case (regAddr)
				`DCSF_OFF_LIVE_ONE: st_nxt.rdData = liveOne;
				`DCSF_OFF_LOG_ONE: st_nxt.rdData = {2'h0, st_r.logOne};
				`DCSF_OFF_LIVE_TWO: st_nxt.rdData = liveTwo;
				`DCSF_OFF_LOG_TWO: st_nxt.rdData = {2'h0, st_r.logTwo};
				default: st_nxt.rdData = `DCSF_RESET_BYTE;
			endcase
		end
		st_nxt.alert = |((st_nxt.logOne & alertEnableOne) | (st_nxt.logTwo & alertEnableTwo));
		st_nxt.freeRun = !convHalt;
		st_nxt.singleGo = convHalt && convSingleReq;
		if (convHalt && convSingleReq) begin
			st_nxt.singleChan = convSingleSel;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		if (!st_r.rdFromMem) begin
			regRdData = st_r.rdData;
		end else if (st_r.rdLow) begin
			regRdData = {memQ[1:0], 6'h00};
		end else begin
			regRdData = memQ[9:2];
		end
	end

	assign hostAlert = st_r.alert;
	assign convFreeRun = st_r.freeRun;
	assign convSingleGo = st_r.singleGo;
	assign convSingleChan = st_r.singleChan;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking dcsf_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_readLive(logic [7:0] a);
		regRd && regAddr == a;
	endsequence

	sequence s_convWrite;
		convResValid && convResChan < 3'h6;
	endsequence

	sequence s_readHigh;
		regRd && inResult && !regAddr[0] && !memWe;
	endsequence

	a_live_switch_on: assert property (s_readLive(`DCSF_OFF_LIVE_ONE) |=> regRdData[7] == $past(passSwitchOn[0]))
		else $error("switch-on bit wrong");

	a_live_power_bad: assert property (s_readLive(`DCSF_OFF_LIVE_TWO)
			|=> regRdData[3] == !$past(pins.pGood[1]) && regRdData[1] == !$past(pins.lowLim[1]))
		else $error("power-bad or low-limit bit wrong");

	a_live_overvolt: assert property (s_readLive(`DCSF_OFF_LIVE_ONE)
			|=> regRdData[0] == $past(pins.highLim[0]) && regRdData[4] == !$past(pins.actN[0]))
		else $error("high-limit or activate bit wrong");

	a_log_sticky: assert property (st_r.logOne[2] && !(regWr && regAddr == `DCSF_OFF_LOG_ONE)
			|=> st_r.logOne[2])
		else $error("log bit dropped without a write");

	a_log_set_wins: assert property (armed && st_r.prevPins.pGood[1] && !pins.pGood[1]
			&& regWr && regAddr == `DCSF_OFF_LOG_TWO |=> st_r.logTwo[3])
		else $error("clear beat a power-bad event");

	a_low_limit_event: assert property (armed && $fell(pins.lowLim[0]) |=> st_r.logOne[1])
		else $error("low-limit event lost");

	a_activate_change: assert property (armed && pins.actN[1] != st_r.prevPins.actN[1] |=> st_r.logTwo[4])
		else $error("activate change lost");

	a_short_event: assert property (convResValid && convResChan == `DCSF_SHUNT_CODE_ONE && convResData > SHORT_LIMIT
			&& !passSwitchOn[0] |=> st_r.logOne[5] && st_r.shortDet[0])
		else $error("switch short not logged");

	a_log_clear: assert property (regWr && regAddr == `DCSF_OFF_LOG_ONE && regWrData[0] == 1'b0 && evOne[0] == 1'b0
			|=> !st_r.logOne[0])
		else $error("overvoltage log bit not cleared");

	a_alert_gate: assert property (##1 hostAlert == |(($past(st_nxt.logOne) & $past(alertEnableOne))
			| ($past(st_nxt.logTwo) & $past(alertEnableTwo))))
		else $error("alert does not match enabled log bits");

	a_result_low_zero: assert property (regRd && inResult && regAddr[0] |=> regRdData[5:0] == 6'h00)
		else $error("low result byte reserved bits not zero");

	a_result_high: assert property (s_convWrite ##1 (s_readHigh and (resIdx == $past(convResChan)))
			|=> regRdData == $past(convResData, 2) >> 2)
		else $error("high result byte does not hold bits nine to two");

	a_halt_single: assert property (convHalt && convSingleReq |=> convSingleGo && !convFreeRun
			&& convSingleChan == $past(convSingleSel))
		else $error("single measurement not issued while halted");

	a_run_no_single: assert property (!convHalt |=> convFreeRun && !convSingleGo)
		else $error("single measurement issued while free-running");

	a_overcurrent_event: assert property (armed && $rose(pins.overCur[1]) |=> st_r.logTwo[2])
		else $error("overcurrent event lost");

	a_live_general: assert property (s_readLive(`DCSF_OFF_LIVE_TWO)
			|=> regRdData[6] == $past(pins.genPin[1]) && regRdData[2] == $past(pins.overCur[1]))
		else $error("general pin or overcurrent bit wrong");

	a_live_short: assert property (s_readLive(`DCSF_OFF_LIVE_ONE) |=> regRdData[5] == $past(st_r.shortDet[0]))
		else $error("short status bit wrong");

	a_halted_write: assert property (regWr && inResult && !convHalt && !convResValid |-> !memWe)
		else $error("result byte written while converter runs");

	a_live_six: assert property (s_readLive(`DCSF_OFF_LIVE_TWO) |=> regRdData[2] == $past(pins.overCur[1]))
		else $error("overcurrent live bit wrong");

	a_live_seven: assert property (s_readLive(`DCSF_OFF_LIVE_ONE) |=> regRdData[1] == !$past(pins.lowLim[0]))
		else $error("undervoltage live bit wrong");

	a_live_four: assert property (s_readLive(`DCSF_OFF_LIVE_TWO) |=> regRdData[4] == !$past(pins.actN[1]))
		else $error("activate live bit wrong");

	a_over_event: assert property (armed && $rose(pins.highLim[0]) |=> st_r.logOne[0])
		else $error("overvoltage event lost");
endmodule
`default_nettype wire

// file: design/dcsf_map.svh
`ifndef DCSF_MAP_SVH
`define DCSF_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define DCSF_OFF_LIVE_ONE 8'hd2
`define DCSF_OFF_LOG_ONE 8'hd3
`define DCSF_OFF_LIVE_TWO 8'hd6
`define DCSF_OFF_LOG_TWO 8'hd7
`define DCSF_OFF_RES_FIRST 8'hd8
`define DCSF_OFF_RES_LAST 8'he3
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DCSF_BIT_SWITCH_ON 7
`define DCSF_BIT_GEN_PIN 6
`define DCSF_BIT_SHORT 5
`define DCSF_BIT_ACTIVE 4
`define DCSF_BIT_POWER_BAD 3
`define DCSF_BIT_OVERCURRENT 2
`define DCSF_BIT_UNDERVOLT 1
`define DCSF_BIT_OVERVOLT 0
`define DCSF_RES_LO_POS 6
`define DCSF_RES_HI_MASK 10'h3fc
`define DCSF_RES_LO_MASK 10'h003
`define DCSF_RES_ALL_MASK 10'h3ff
// ----------------------------------------
// Sizes, codes and reset values
// ----------------------------------------
`define DCSF_RES_CHANNELS 6
`define DCSF_SHUNT_CODE_ONE 3'h4
`define DCSF_SHUNT_CODE_TWO 3'h5
`define DCSF_SHORT_LIMIT 10'h001
`define DCSF_ARM_CYCLES 2'h3
`define DCSF_RESET_BYTE 8'h00
`define DCSF_RESET_LOG 6'h00
`endif

// file: design/dcsf_pkg.sv
`default_nettype none
package dcsf_pkg;
	typedef logic [7:0] dcsf_byte_t;
	typedef logic [9:0] dcsf_result_t;
	typedef logic [2:0] dcsf_code_t;
	typedef logic [5:0] dcsf_log_t;
	// One bit per channel for every pin level
	typedef struct packed {
		logic [1:0] genPin, actN, pGood, lowLim, highLim, overCur;
	} dcsf_pins_t;
endpackage
`default_nettype wire

// file: design/dcsf_sync.sv
`default_nettype none
module dcsf_sync import dcsf_pkg::*; #(
	parameter int WIDTH = 12
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} dcsf_sync_state_t;
	dcsf_sync_state_t st_r;
	dcsf_sync_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.first = asyncIn;
		st_nxt.second = st_r.first;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign syncOut = st_r.second;
endmodule
`default_nettype wire

// file: design/dcsf_result_mem.sv
`default_nettype none
module dcsf_result_mem import dcsf_pkg::*; #(
	parameter int DEPTH = 6,
	parameter int WIDTH = 10
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic wrEn,
	input wire logic [2:0] wrAddr,
	input wire logic [WIDTH-1:0] wrData,
	input wire logic [WIDTH-1:0] wrMask,
	input wire logic [2:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] words;
		logic [WIDTH-1:0] q;
	} dcsf_mem_state_t;
	dcsf_mem_state_t st_r;
	dcsf_mem_state_t st_nxt;

	// Read returns the word as it stood before a same-cycle write
	always_comb begin
		st_nxt = st_r;
		st_nxt.q = (int'(rdAddr) < DEPTH) ? st_r.words[rdAddr] : '0;
		if (wrEn && int'(wrAddr) < DEPTH) begin
			st_nxt.words[wrAddr] = (st_r.words[wrAddr] & ~wrMask) | (wrData & wrMask);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdData = st_r.q;
endmodule
`default_nettype wire

// file: dv/dcsf_host_model.sv
`default_nettype none
// ----------------------------------------
// Management host model
// ----------------------------------------
module dcsf_host_model import dcsf_pkg::*; (
	input wire logic core_clk,
	output logic [7:0] regAddr,
	output logic regWr,
	output logic regRd,
	output logic [7:0] regWrData,
	input wire logic [7:0] regRdData,
	output logic convHalt,
	output logic convSingleReq,
	output logic [2:0] convSingleSel,
	output logic [5:0] alertEnableOne,
	output logic [5:0] alertEnableTwo
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regAddr = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		regWrData = 8'h00;
		convHalt = 1'b0;
		convSingleReq = 1'b0;
		convSingleSel = 3'h0;
		alertEnableOne = 6'h00;
		alertEnableTwo = 6'h00;
	end
	// Released bus lines show the inverse, so stale values never look valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		regAddr <= ~a;
		#1;
		d = regRdData;
	endtask
	// Halt goes up before the host writes a result byte that must land
	task automatic halt(input logic h);
		@(posedge core_clk);
		convHalt <= h;
		@(posedge core_clk);
		#1;
	endtask
	task automatic single(input logic [2:0] s);
		@(posedge core_clk);
		convSingleReq <= 1'b1;
		convSingleSel <= s;
		@(posedge core_clk);
		convSingleReq <= 1'b0;
		convSingleSel <= ~s;
		#1;
	endtask
	task automatic alerts(input logic [5:0] a1, input logic [5:0] a2);
		@(posedge core_clk);
		alertEnableOne <= a1;
		alertEnableTwo <= a2;
		@(posedge core_clk);
		#1;
	endtask
endmodule
`default_nettype wire

// file: dv/test_dual_channel_status_fault_regs.sv
`default_nettype none
module test_dual_channel_status_fault_regs;
	import dcsf_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, rst_n, regWr, regRd, convHalt, convSingleReq, g1, g2, cv;
	logic convFreeRun, convSingleGo, hostAlert;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [5:0] en1, en2;
	logic [2:0] convSingleSel, convSingleChan, cch;
	logic [1:0] sw, actN, pg, lo, hi, oc;
	logic [9:0] cdat;
	dcsf_result_t res [6];
	int err_count = 0;
	int compares = 0;
	dcsf_regs dut (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWrData(regWrData), .regRdData(regRdData), .passSwitchOn(sw), .generalPinOne(g1),
		.generalPinTwo(g2), .activateN(actN), .powerGoodFeedback(pg), .inputLowLimitPin(lo),
		.inputHighLimitPin(hi), .overcurrentPin(oc), .alertEnableOne(en1), .alertEnableTwo(en2),
		.convHalt(convHalt), .convSingleReq(convSingleReq), .convSingleSel(convSingleSel),
		.convResValid(cv), .convResChan(cch), .convResData(cdat), .convFreeRun(convFreeRun),
		.convSingleGo(convSingleGo), .convSingleChan(convSingleChan), .hostAlert(hostAlert));
	dcsf_host_model host (.core_clk(core_clk), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
		.regWrData(regWrData), .regRdData(regRdData), .convHalt(convHalt), .convSingleReq(convSingleReq),
		.convSingleSel(convSingleSel), .alertEnableOne(en1), .alertEnableTwo(en2));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic give_verdict;
		if (err_count == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, exp);
	endtask
	task automatic conv(input logic [2:0] ch, input logic [9:0] d);
		@(posedge core_clk);
		cv <= 1'b1;
		cch <= ch;
		cdat <= d;
		@(posedge core_clk);
		cv <= 1'b0;
		cdat <= ~d;
		@(posedge core_clk);
	endtask
	task automatic idle_pins;
		@(posedge core_clk);
		{sw, g1, g2, oc, hi} <= 8'h00;
		{actN, pg, lo} <= 6'h3f;
		repeat (4) @(posedge core_clk);
		#1;
	endtask
	// Hang guard
	initial begin
		repeat (20000) @(posedge core_clk);
		err_count++;
		give_verdict();
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		{sw, g1, g2, oc, hi, cv, cch, cdat} = 22'h0;
		{actN, pg, lo} = 6'h3f;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		rdc(8'hd3, 8'h00);
		rdc(8'hd7, 8'h00);
		host.wr(8'h50, 8'hff);
		rdc(8'h50, 8'h00);
		// Every live condition but the short active on channel one, only switch-on and overvoltage on channel two
		@(posedge core_clk);
		{sw, g1, g2} <= 4'he;
		{actN, pg, lo} <= 6'h2a;
		oc <= 2'b01;
		hi <= 2'b11;
		repeat (4) @(posedge core_clk);
		#1 chk(hostAlert, 8'h00);
		rdc(8'hd2, 8'hdf);
		rdc(8'hd6, 8'h81);
		rdc(8'hd3, 8'h1f);
		rdc(8'hd7, 8'h01);
		host.wr(8'hd2, 8'h00);
		rdc(8'hd2, 8'hdf);
		host.alerts(6'h20, 6'h00);
		chk(hostAlert, 8'h00);
		host.alerts(6'h01, 6'h00);
		chk(hostAlert, 8'h01);
		host.wr(8'hd3, 8'h1e);
		@(posedge core_clk);
		#1 chk(hostAlert, 8'h00);
		rdc(8'hd3, 8'h1e);
		host.alerts(6'h01, 6'h01);
		chk(hostAlert, 8'h01);
		host.wr(8'hd7, 8'h00);
		@(posedge core_clk);
		#1 chk(hostAlert, 8'h00);
		// Back to idle: only the activate change logs again
		idle_pins();
		rdc(8'hd2, 8'h00);
		rdc(8'hd6, 8'h00);
		rdc(8'hd3, 8'h1e);
		rdc(8'hd7, 8'h00);
		host.wr(8'hd3, 8'h00);
		rdc(8'hd3, 8'h00);
		// Switch short seen through the shunt readings
		host.alerts(6'h20, 6'h20);
		conv(3'h4, 10'h002);
		rdc(8'hd2, 8'h20);
		rdc(8'hd3, 8'h20);
		chk(hostAlert, 8'h01);
		@(posedge core_clk);
		sw <= 2'b10;
		conv(3'h5, 10'h3ff);
		rdc(8'hd6, 8'h80);
		rdc(8'hd7, 8'h00);
		conv(3'h4, 10'h001);
		rdc(8'hd2, 8'h00);
		rdc(8'hd3, 8'h20);
		host.wr(8'hd3, 8'h00);
		host.alerts(6'h00, 6'h00);
		// Result bytes of every converter channel
		@(posedge core_clk);
		sw <= 2'b11;
		for (int k = 0; k < 6; k++) begin
			res[k] = 10'(10'h2b5 + 10'h49 * k);
			conv(3'(k), res[k]);
		end
		for (int k = 0; k < 6; k++) begin
			rdc(8'(8'hd8 + 2 * k), res[k][9:2]);
			rdc(8'(8'hd9 + 2 * k), {res[k][1:0], 6'h00});
		end
		// Host writes only take while halted
		chk(convFreeRun, 8'h01);
		host.single(3'h2);
		chk(convSingleGo, 8'h00);
		host.wr(8'hd8, 8'h12);
		rdc(8'hd8, res[0][9:2]);
		host.halt(1'b1);
		chk(convFreeRun, 8'h00);
		host.single(3'h5);
		chk(convSingleGo, 8'h01);
		chk(convSingleChan, 8'h05);
		host.wr(8'hd8, 8'h12);
		rdc(8'hd8, 8'h12);
		host.wr(8'hd9, 8'hff);
		rdc(8'hd9, 8'hc0);
		rdc(8'hda, res[1][9:2]);
		give_verdict();
	end
endmodule
`default_nettype wire
